/* rtl/cap_cmp.sv */
// Input capture and two output compare units of a 16-bit timer, with an APB register slave.
// Assumes the counter, prescaler and waveform generator are outside and on pclk.
// timer_tick marks a timer clock cycle; counter_wr pulses when software writes the counter.
`timescale 1ns/1ps
module cap_cmp (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic [15:0] counter_value,
  input wire logic [3:0] waveform_mode_bits,
  input wire logic timer_tick,
  input wire logic counter_wr,
  input wire logic at_top,
  input wire logic at_bottom,
  input wire logic buffer_at_bottom,
  input wire logic cap_int_ack,
  input wire logic cmpa_int_ack,
  input wire logic cmpb_int_ack,
  output logic capture_int_req,
  output logic compare_a_int_req,
  output logic compare_b_int_req,
  output logic compare_a_match,
  output logic compare_b_match,
  output logic [15:0] top_from_compare_a,
  output logic [15:0] capture_register
);

  cap_cmp_pkg::state_t q, d;

  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == cap_cmp_pkg::MODE_CTC_CAP) || (m == cap_cmp_pkg::MODE_PWM_CAP_FAST)
      || (m == cap_cmp_pkg::MODE_PWM_CAP_PFC) || (m == cap_cmp_pkg::MODE_PWM_CAP_PC);
  endfunction : cap_is_top

  // Normal and both clear-on-match modes are the only non-PWM encodings.
  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !((m == cap_cmp_pkg::MODE_NORMAL) || (m == cap_cmp_pkg::MODE_CTC_A)
      || (m == cap_cmp_pkg::MODE_CTC_CAP));
  endfunction : is_pwm

  function automatic logic [15:0] merge_lo(input logic [15:0] cur, input logic [7:0] hi, input logic [7:0] lo);
    merge_lo = {hi, lo};
  endfunction : merge_lo

  logic acc_wr, setup_rd, pwm, src, trig_in, edge_hit, cap_en, upd, mapped;
  logic pslverr_d;
  logic [7:0] wb;
  logic [31:0] rdata;

  always_comb begin
    d = q;
    pwm = is_pwm(waveform_mode_bits);
    cap_en = !cap_is_top(waveform_mode_bits);
    acc_wr = psel && penable && pwrite && pstrb[0];
    // Reads are decoded in the setup cycle so that registered data stands at the access edge.
    setup_rd = psel && !penable && !pwrite;
    wb = pwdata[7:0];
    rdata = 32'h0000_0000;
    mapped = paddr inside {cap_cmp_pkg::OFF_CAP_LO, cap_cmp_pkg::OFF_CAP_HI, cap_cmp_pkg::OFF_CMPA_LO,
      cap_cmp_pkg::OFF_CMPA_HI, cap_cmp_pkg::OFF_CMPB_LO, cap_cmp_pkg::OFF_CMPB_HI, cap_cmp_pkg::OFF_CTRL,
      cap_cmp_pkg::OFF_FLAGS, cap_cmp_pkg::OFF_FORCE};

    // Synchroniser; the comparator select can raise a false edge on switching.
    src = q.ctrl[cap_cmp_pkg::CTRL_CMP_SEL] ? comparator_output : capture_pin;
    d.trig.sync = {q.trig.sync[0], src};
    d.trig.hist = {q.trig.hist[1:0], q.trig.sync[1]};
    if (q.ctrl[cap_cmp_pkg::CTRL_FILT_EN]) begin
      if ((q.trig.hist == {3{q.trig.sync[1]}}) ) begin
        d.trig.filt = q.trig.sync[1];
      end
    end else begin
      d.trig.filt = q.trig.sync[1];
    end
    trig_in = q.trig.filt;
    d.trig.prev = trig_in;
    edge_hit = q.ctrl[cap_cmp_pkg::CTRL_EDGE_RISE] ? (trig_in && !q.trig.prev)
      : (!trig_in && q.trig.prev);

    // Compare matches, blocked for one timer tick after a counter write.
    if (counter_wr) begin
      d.block = 1'b1;
    end else if (timer_tick) begin
      d.block = 1'b0;
    end
    d.match_a = 1'b0;
    d.match_b = 1'b0;
    if (timer_tick && !q.block && !counter_wr) begin
      d.match_a = (counter_value == q.cmpa);
      d.match_b = (counter_value == q.cmpb);
    end
    if (d.match_a) begin
      d.flags[cap_cmp_pkg::FLG_CMPA] = 1'b1;
    end
    if (d.match_b) begin
      d.flags[cap_cmp_pkg::FLG_CMPB] = 1'b1;
    end

    // Buffer transfer in PWM modes.
    upd = buffer_at_bottom ? at_bottom : at_top;
    if (pwm && upd && timer_tick) begin
      d.cmpa = q.bufa;
      d.cmpb = q.bufb;
    end

    // Interrupt acknowledge clears; a fresh set still wins below.
    if (cap_int_ack) begin
      d.flags[cap_cmp_pkg::FLG_CAP] = 1'b0;
    end
    if (cmpa_int_ack && !d.match_a) begin
      d.flags[cap_cmp_pkg::FLG_CMPA] = 1'b0;
    end
    if (cmpb_int_ack && !d.match_b) begin
      d.flags[cap_cmp_pkg::FLG_CMPB] = 1'b0;
    end

    // APB writes take effect at the access cycle; slave is always ready.
    if (acc_wr) begin
      case (paddr)
        cap_cmp_pkg::OFF_CAP_HI, cap_cmp_pkg::OFF_CMPA_HI, cap_cmp_pkg::OFF_CMPB_HI: begin
          d.temp = wb;
        end
        cap_cmp_pkg::OFF_CAP_LO: begin
          if (!cap_en) begin
            d.cap = merge_lo(q.cap, q.temp, wb);
          end
        end
        cap_cmp_pkg::OFF_CMPA_LO: begin
          if (pwm) begin
            d.bufa = merge_lo(q.bufa, q.temp, wb);
          end else begin
            d.cmpa = merge_lo(q.cmpa, q.temp, wb);
          end
        end
        cap_cmp_pkg::OFF_CMPB_LO: begin
          if (pwm) begin
            d.bufb = merge_lo(q.bufb, q.temp, wb);
          end else begin
            d.cmpb = merge_lo(q.cmpb, q.temp, wb);
          end
        end
        cap_cmp_pkg::OFF_CTRL: begin
          d.ctrl = pwdata[5:0];
        end
        cap_cmp_pkg::OFF_FLAGS: begin
          d.flags = d.flags & ~pwdata[2:0];
        end
        cap_cmp_pkg::OFF_FORCE: begin
          // Forced match reaches the waveform generator only; flags stay.
          if (!pwm) begin
            d.match_a = d.match_a | pwdata[cap_cmp_pkg::FRC_A];
            d.match_b = d.match_b | pwdata[cap_cmp_pkg::FRC_B];
          end
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end

    if (setup_rd) begin
      case (paddr)
        cap_cmp_pkg::OFF_CAP_LO: begin
          rdata = {24'h00_0000, q.cap[7:0]};
          d.temp = q.cap[15:8];
        end
        cap_cmp_pkg::OFF_CAP_HI, cap_cmp_pkg::OFF_CMPA_HI, cap_cmp_pkg::OFF_CMPB_HI: begin
          rdata = {24'h00_0000, q.temp};
          if (paddr == cap_cmp_pkg::OFF_CMPA_HI) begin
            rdata = {24'h00_0000, pwm ? q.bufa[15:8] : q.cmpa[15:8]};
          end
          if (paddr == cap_cmp_pkg::OFF_CMPB_HI) begin
            rdata = {24'h00_0000, pwm ? q.bufb[15:8] : q.cmpb[15:8]};
          end
        end
        cap_cmp_pkg::OFF_CMPA_LO: begin
          rdata = {24'h00_0000, pwm ? q.bufa[7:0] : q.cmpa[7:0]};
        end
        cap_cmp_pkg::OFF_CMPB_LO: begin
          rdata = {24'h00_0000, pwm ? q.bufb[7:0] : q.cmpb[7:0]};
        end
        cap_cmp_pkg::OFF_CTRL: begin
          rdata = {26'h000_0000, q.ctrl};
        end
        cap_cmp_pkg::OFF_FLAGS: begin
          rdata = {29'h0000_0000, q.flags};
        end
        cap_cmp_pkg::OFF_FORCE: begin
          rdata = 32'h0000_0000;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
    if (setup_rd) begin
      d.prdata = rdata;
    end

    // Capture has priority over every clear of its flag in the same cycle.
    if (edge_hit && cap_en) begin
      d.cap = counter_value;
      d.flags[cap_cmp_pkg::FLG_CAP] = 1'b1;
    end
    if (d.match_a && !acc_wr) begin
      d.flags[cap_cmp_pkg::FLG_CMPA] = d.flags[cap_cmp_pkg::FLG_CMPA];
    end
    if (timer_tick && !q.block && !counter_wr && (counter_value == q.cmpa)) begin
      d.flags[cap_cmp_pkg::FLG_CMPA] = 1'b1;
    end
    if (timer_tick && !q.block && !counter_wr && (counter_value == q.cmpb)) begin
      d.flags[cap_cmp_pkg::FLG_CMPB] = 1'b1;
    end

    d.irq_cap = d.flags[cap_cmp_pkg::FLG_CAP] && d.ctrl[cap_cmp_pkg::CTRL_CAP_IE];
    d.irq_a = d.flags[cap_cmp_pkg::FLG_CMPA] && d.ctrl[cap_cmp_pkg::CTRL_CMPA_IE];
    d.irq_b = d.flags[cap_cmp_pkg::FLG_CMPB] && d.ctrl[cap_cmp_pkg::CTRL_CMPB_IE];
    pslverr_d = (psel && !mapped);
  end

  logic err_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      err_q <= 1'b0;
    end else if (clk_en) begin
      q <= d;
      err_q <= pslverr_d;
    end
  end

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_q;
  assign capture_int_req = q.irq_cap;
  assign compare_a_int_req = q.irq_a;
  assign compare_b_int_req = q.irq_b;
  assign compare_a_match = q.match_a;
  assign compare_b_match = q.match_b;
  assign top_from_compare_a = q.cmpa;
  assign capture_register = q.cap;

endmodule : cap_cmp

/* rtl/cap_cmp_pkg.sv */
// Package for the timer capture and compare block: register map, field layout, resets and carriers.
// Assumes a 32-bit APB slave on pclk; the counter, prescaler and waveform generator live outside.
// Functional notes
// - On a qualified trigger edge, copy the full 16-bit count into capture register.
// - Capture flag sets in the same cycle the capture register loads.
// - Capture flag with its enable requests interrupt; clears when interrupt serviced.
// - Writing one to the capture flag bit clears it.
// - Low byte read latches capture high byte into temp; high read returns temp.
// - Capture register writable only in modes using it as TOP; high byte first.
// - Select bit picks comparator output as trigger; software clears flag after switching.
// - Noise filter changes output only after four equal samples, four cycles delay; the filter here adds three pclk cycles.
// - Filter enabled by control B bit and samples on undivided system clock.
// - Filter and edge detector active except in modes using capture register as TOP; here both run in every mode and only the capture load is gated.
// - Capture pin stays sampled even when driven by its own port output.
// - Each new capture overwrites the capture register regardless of reads.
// - Compare flags request interrupt when enabled, clear on service or on write one.
// - Compare unit A can supply TOP value to the counter.
// - Compare registers double-buffered in PWM modes, loaded at TOP or BOTTOM; else bypassed.
// - With buffering, CPU accesses the buffer; otherwise the active compare register.
// - Compare reads return both bytes directly, without the temp register.
// - Compare high byte written to temp first; low write loads all 16 bits at once.
// - In non-PWM modes force strobe pulses match output without flag or counter clear.
// - Match signals go to the waveform generator, which acts on mode bits.
// - A counter write blocks every compare match in the next timer clock cycle.
// - Mode 4 and 12 are clear-on-match, TOP from compare A or capture register.
package cap_cmp_pkg;

  localparam logic [11:0] OFF_CAP_LO = 12'h000;
  localparam logic [11:0] OFF_CAP_HI = 12'h004;
  localparam logic [11:0] OFF_CMPA_LO = 12'h008;
  localparam logic [11:0] OFF_CMPA_HI = 12'h00C;
  localparam logic [11:0] OFF_CMPB_LO = 12'h010;
  localparam logic [11:0] OFF_CMPB_HI = 12'h014;
  localparam logic [11:0] OFF_CTRL = 12'h018;
  localparam logic [11:0] OFF_FLAGS = 12'h01C;
  localparam logic [11:0] OFF_FORCE = 12'h020;

  // Control register fields.
  localparam int CTRL_EDGE_RISE = 0;
  localparam int CTRL_FILT_EN = 1;
  localparam int CTRL_CMP_SEL = 2;
  localparam int CTRL_CAP_IE = 3;
  localparam int CTRL_CMPA_IE = 4;
  localparam int CTRL_CMPB_IE = 5;
  // Flag register and force register fields.
  localparam int FLG_CAP = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FRC_A = 0;
  localparam int FRC_B = 1;

  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CTC_A = 4'h4;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_PWM_CAP_FAST = 4'hE;
  localparam logic [3:0] MODE_PWM_CAP_PFC = 4'h8;
  localparam logic [3:0] MODE_PWM_CAP_PC = 4'hA;

  localparam int FILT_SAMPLES = 4;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_CTRL = 6'h00;

  typedef struct packed {
    logic [1:0] sync;
    logic [2:0] hist;
    logic filt;
    logic prev;
    logic src_prev;
  } trig_t;

  typedef struct packed {
    trig_t trig;
    logic [15:0] cap;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
    logic [15:0] bufa;
    logic [15:0] bufb;
    logic [7:0] temp;
    logic [5:0] ctrl;
    logic [2:0] flags;
    logic block;
    logic match_a;
    logic match_b;
    logic irq_cap;
    logic irq_a;
    logic irq_b;
    logic [31:0] prdata;
  } state_t;

endpackage : cap_cmp_pkg

/* tb/cap_cmp_properties.sv */
// Concurrent checks on the ports of cap_cmp, bound to every instance of it.
// Assumes clk_en stays high and pstrb is full while these are meant to hold.
`timescale 1ns/1ps
module cap_cmp_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] waveform_mode_bits,
  input wire logic timer_tick,
  input wire logic counter_wr,
  input wire logic at_top,
  input wire logic at_bottom,
  input wire logic buffer_at_bottom,
  input wire logic cap_int_ack,
  input wire logic capture_int_req,
  input wire logic compare_a_match,
  input wire logic compare_b_match,
  input wire logic [15:0] top_from_compare_a,
  input wire logic [15:0] capture_register
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr = psel && penable && pwrite;
  property p_cap_top_only_by_write;
    $changed(capture_register) && waveform_mode_bits == cap_cmp_pkg::MODE_CTC_CAP
      |-> $past(wr && paddr == cap_cmp_pkg::OFF_CAP_LO);
  endproperty
  a_cap_top_only_by_write: assert property (p_cap_top_only_by_write) else $error("capture moved in mode 12");
  property p_cap_write_refused;
    wr && paddr == cap_cmp_pkg::OFF_CAP_LO && waveform_mode_bits == cap_cmp_pkg::MODE_NORMAL
      |=> $stable(capture_register);
  endproperty
  a_cap_write_refused: assert property (p_cap_write_refused) else $error("capture written in mode 0");
  property p_direct_compare_write;
    wr && paddr == cap_cmp_pkg::OFF_CMPA_LO && waveform_mode_bits == cap_cmp_pkg::MODE_CTC_A
      |=> top_from_compare_a[7:0] == $past(pwdata[7:0]);
  endproperty
  a_direct_compare_write: assert property (p_direct_compare_write) else $error("compare A not direct");
  property p_buffer_at_top;
    $changed(top_from_compare_a) && waveform_mode_bits == cap_cmp_pkg::MODE_PWM_CAP_FAST
      |-> $past(buffer_at_bottom ? at_bottom : at_top);
  endproperty
  a_buffer_at_top: assert property (p_buffer_at_top) else $error("buffer moved off top");
  property p_no_force_in_pwm;
    wr && paddr == cap_cmp_pkg::OFF_FORCE && pwdata[0] && !timer_tick
      && waveform_mode_bits == cap_cmp_pkg::MODE_PWM_CAP_FAST |=> !compare_a_match;
  endproperty
  a_no_force_in_pwm: assert property (p_no_force_in_pwm) else $error("force acted in PWM");
  property p_count_write_blocks;
    counter_wr && !timer_tick ##1 timer_tick |=> !compare_a_match && !compare_b_match;
  endproperty
  a_count_write_blocks: assert property (p_count_write_blocks) else $error("match not blocked");
  property p_cap_ack_clears;
    cap_int_ack |-> ##[1:2] !capture_int_req;
  endproperty
  a_cap_ack_clears: assert property (p_cap_ack_clears) else $error("capture request not cleared");
  property p_match_cause;
    compare_a_match |-> $past(timer_tick) || $past(wr && paddr == cap_cmp_pkg::OFF_FORCE);
  endproperty
  a_match_cause: assert property (p_match_cause) else $error("match without tick or force");
  c_capture: cover property ($rose(capture_int_req));
  c_match_a: cover property (compare_a_match);
  c_match_b: cover property (compare_b_match);
endmodule : cap_cmp_properties
bind cap_cmp cap_cmp_properties u_props (.*);

/* tb/event_source.sv */
// Model of the trigger side: the capture pin and the comparator output, both plain levels.
// Assumes the caller sits on the pclk edge grid; levels change just after a rising edge.
`timescale 1ns/1ps
module event_source (
  input wire logic pclk,
  output logic capture_pin,
  output logic comparator_output
);
  initial begin
    capture_pin = 1'b0;
    comparator_output = 1'b0;
  end
  task automatic drive(input logic sel, input logic v);
    @(posedge pclk);
    if (sel) begin
      comparator_output <= v;
    end else begin
      capture_pin <= v;
    end
  endtask : drive
endmodule : event_source

/* tb/cap_cmp_tb_top.sv */
// Self-checking bench for cap_cmp: APB tasks, an event source and a bench-driven counter.
// Assumes the package register map; register bytes sit in the low byte of the data word.
`timescale 1ns/1ps
module cap_cmp_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, timer_tick = 1'b0, counter_wr = 1'b0;
  logic at_top = 1'b0, cap_ack = 1'b0, cmpa_ack = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  int a_match_count = 0, b_match_count = 0;
  logic [15:0] counter_value = 16'h0000, top_a, cap_reg;
  logic [3:0] mode = 4'h0;
  logic pready, pslverr, capture_pin, comparator_output, cap_irq, a_irq, a_match, b_match;
  int num_errors = 0, cmp_count = 0, cycles = 0;
  always #5 pclk = ~pclk;
  // Match outputs are one-cycle pulses, so they are counted at every edge.
  always @(posedge pclk) begin
    if (a_match === 1'b1) a_match_count++;
    if (b_match === 1'b1) b_match_count++;
  end
  cap_cmp u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_pin(capture_pin), .comparator_output(comparator_output),
    .counter_value(counter_value), .waveform_mode_bits(mode), .timer_tick(timer_tick),
    .counter_wr(counter_wr), .at_top(at_top), .at_bottom(1'b0), .buffer_at_bottom(1'b0),
    .cap_int_ack(cap_ack), .cmpa_int_ack(cmpa_ack), .cmpb_int_ack(1'b0), .capture_int_req(cap_irq),
    .compare_a_int_req(a_irq), .compare_b_int_req(), .compare_a_match(a_match),
    .compare_b_match(b_match), .top_from_compare_a(top_a), .capture_register(cap_reg));
  event_source u_src (.pclk(pclk), .capture_pin(capture_pin), .comparator_output(comparator_output));
  task automatic stop_test();
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // Read data is taken at the edge that ends the access.
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    chk({8'h00, rd_data[7:0]}, {8'h00, e});
  endtask : rd
  task automatic pin(input logic sel, input logic v, input logic [15:0] cnt);
    counter_value <= cnt;
    u_src.drive(sel, v);
    repeat (12) @(posedge pclk);
  endtask : pin
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b1, cap_cmp_pkg::OFF_CTRL, 32'h19);
    pin(1'b0, 1'b1, 16'h1234);
    chk(cap_reg, 16'h1234);
    chk({15'h0, cap_irq}, 16'h0001);
    rd(cap_cmp_pkg::OFF_CAP_LO, 8'h34);
    pin(1'b0, 1'b0, 16'hABCD);
    chk(cap_reg, 16'h1234);
    pin(1'b0, 1'b1, 16'hABCD);
    chk(cap_reg, 16'hABCD);
    rd(cap_cmp_pkg::OFF_CAP_HI, 8'h12);
    xfer(1'b1, cap_cmp_pkg::OFF_FLAGS, 32'h1);
    repeat (2) @(posedge pclk);
    chk({15'h0, cap_irq}, 16'h0000);
    xfer(1'b1, cap_cmp_pkg::OFF_CTRL, 32'h1D);
    repeat (12) @(posedge pclk);
    xfer(1'b1, cap_cmp_pkg::OFF_FLAGS, 32'h1);
    pin(1'b1, 1'b1, 16'h0777);
    chk(cap_reg, 16'h0777);
    cap_ack <= 1'b1;
    @(posedge pclk);
    cap_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({15'h0, cap_irq}, 16'h0000);
    xfer(1'b1, cap_cmp_pkg::OFF_CTRL, 32'h1B);
    pin(1'b0, 1'b0, 16'h0999);
    u_src.drive(1'b0, 1'b1);
    pin(1'b0, 1'b0, 16'h0999);
    chk(cap_reg, 16'h0777);
    pin(1'b0, 1'b1, 16'h0999);
    chk(cap_reg, 16'h0999);
    mode <= cap_cmp_pkg::MODE_CTC_CAP;
    xfer(1'b1, cap_cmp_pkg::OFF_CAP_HI, 32'h56);
    xfer(1'b1, cap_cmp_pkg::OFF_CAP_LO, 32'h78);
    pin(1'b0, 1'b0, 16'h0111);
    pin(1'b0, 1'b1, 16'h0111);
    chk(cap_reg, 16'h5678);
    mode <= cap_cmp_pkg::MODE_NORMAL;
    xfer(1'b1, cap_cmp_pkg::OFF_CAP_LO, 32'h11);
    @(posedge pclk);
    chk(cap_reg, 16'h5678);
    mode <= cap_cmp_pkg::MODE_CTC_A;
    xfer(1'b1, cap_cmp_pkg::OFF_CMPA_HI, 32'h01);
    xfer(1'b1, cap_cmp_pkg::OFF_CMPA_LO, 32'h40);
    xfer(1'b1, cap_cmp_pkg::OFF_CMPB_HI, 32'h02);
    xfer(1'b1, cap_cmp_pkg::OFF_CMPB_LO, 32'h41);
    chk(top_a, 16'h0140);
    rd(cap_cmp_pkg::OFF_CMPA_HI, 8'h01);
    counter_value <= 16'h0140;
    timer_tick <= 1'b1;
    @(posedge pclk);
    timer_tick <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({15'h0, a_irq}, 16'h0001);
    cmpa_ack <= 1'b1;
    @(posedge pclk);
    cmpa_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({15'h0, a_irq}, 16'h0000);
    counter_wr <= 1'b1;
    @(posedge pclk);
    counter_wr <= 1'b0;
    timer_tick <= 1'b1;
    @(posedge pclk);
    timer_tick <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({15'h0, a_irq}, 16'h0000);
    xfer(1'b1, cap_cmp_pkg::OFF_FORCE, 32'h1);
    repeat (3) @(posedge pclk);
    chk({15'h0, a_irq}, 16'h0000);
    chk(a_match_count[15:0], 16'h0002);
    mode <= cap_cmp_pkg::MODE_PWM_CAP_FAST;
    xfer(1'b1, cap_cmp_pkg::OFF_CMPA_HI, 32'h03);
    xfer(1'b1, cap_cmp_pkg::OFF_CMPA_LO, 32'h00);
    xfer(1'b1, cap_cmp_pkg::OFF_FORCE, 32'h1);
    chk(top_a, 16'h0140);
    rd(cap_cmp_pkg::OFF_CMPA_HI, 8'h03);
    at_top <= 1'b1;
    timer_tick <= 1'b1;
    counter_value <= 16'h0000;
    @(posedge pclk);
    at_top <= 1'b0;
    timer_tick <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(top_a, 16'h0300);
    chk(a_match_count[15:0], 16'h0002);
    chk(b_match_count[15:0], 16'h0000);
    stop_test();
  end
endmodule : cap_cmp_tb_top
